/* File: cie_regs.svh */
// command and immediate execution: encodings, field positions, reset values
// assumes a 16-bit instruction word with bit 0 of the printed numbering in bit 15
`ifndef CIE_REGS_SVH
`define CIE_REGS_SVH
`define CIE_OP_HI        15
`define CIE_OP_LO        12
`define CIE_OP_COMMAND   4'h1
`define CIE_OP_LOAD_IMM  4'h2
`define CIE_OP_AND_IMM   4'h3
`define CIE_OP_OR_IMM    4'h4
`define CIE_OP_XOR_IMM   4'h5
`define CIE_OP_ADD_IMM   4'h6
`define CIE_OP_SUB_IMM   4'h7
`define CIE_MOD_N        11
`define CIE_MOD_SKIP_IF_NOT_NEGATIVE    10
`define CIE_MOD_SKIP_IF_RESULT_NOT_ZERO 9
`define CIE_MOD_NC       8
`define CIE_FN_SER_OUT   7
`define CIE_FN_LOAD_A    6
`define CIE_FN_LOAD_MASK 5
`define CIE_FN_SER_IN    4
`define CIE_FN_SET_EN    3
`define CIE_FN_CLR_EN    2
`define CIE_FN_WAIT      1
`define CIE_FN_SHUTDOWN  0
`define CIE_RST_BYTE     8'h00
`define CIE_RESTART_PC   16'h0000
`endif

/* File: cie_pkg.sv */
// command and immediate execution: shared types
// assumes cie_regs.svh is on the include path
package cie_pkg;
    typedef enum logic [2:0] {
        CIE_RUN  = 3'b001,
        CIE_WAIT = 3'b010,
        CIE_DOWN = 3'b100
    } cie_state_t;
    // pin inputs that pass the three-stage filter
    typedef struct packed {
        logic [7:0] irq;
        logic [7:0] switches;
        logic       serial_in;
        logic       restart;
        logic       power_ok;
    } cie_pins_t;
    typedef struct packed {
        logic [7:0] acc;
        logic       carry;
        logic [7:0] mask;
        logic       enable;
        logic       ser_out;
    } cie_arch_t;
endpackage

/* File: cie_exec.sv */
// command and immediate instruction execution inside the processor core
// assumes the sequencer holds INSTR_VALID high for one cycle per instruction, only
// while INSTR_READY is high, and fetches at START_PC when START_ZERO pulses
`timescale 1ns/1ps
`include "cie_regs.svh"

// Summary of operation
// RQ1: command skips tested after all functions
// RQ2: no interrupt until one more instruction
// RQ3: bit 08 copies carry to serial out
// RQ4: bit 09 loads accumulator from switches
// RQ5: bit 10 loads mask from accumulator
// RQ6: bit 11 loads carry from serial in
// RQ7: bit 12 sets, 13 clears enable
// RQ8: bit 14 waits until interrupt or restart
// RQ9: after wait, next instruction before interrupt
// RQ10: bit 15 starts orderly self-initialisation
// RQ11: restart at location 0000 after power
// RQ12: program avoids conflicting function pairs
// RQ13: immediate operands: accumulator and literal field
// RQ14: immediate skip on requested valid conditions
// RQ15: suppress keeps accumulator and carry
// RQ16: load immediate writes literal, carry kept
// RQ17: logical immediates bitwise, carry kept
// RQ18: add stores sum and carry out
// RQ19: subtract stores difference and borrow
// RQ20: negative means msb set; functions first
module cie_exec
    import cie_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    input  wire logic        INSTR_VALID,
    input  wire logic [15:0] INSTR,
    input  wire logic [7:0]  PANEL_SWITCHES,
    input  wire logic        SERIAL_IN,
    input  wire logic        PANEL_RESTART,
    input  wire logic        POWER_OK,
    input  wire logic [7:0]  IRQ,
    output logic             INSTR_READY,
    output logic [7:0]       ACC,
    output logic             CARRY,
    output logic [7:0]       INT_MASK,
    output logic             INT_ENABLE,
    output logic             SERIAL_OUT,
    output logic             SKIP,
    output logic             DONE,
    output logic             INT_TAKE,
    output logic             WAITING,
    output logic             SHUTDOWN_INIT,
    output logic             START_ZERO,
    output logic [15:0]      START_PC
);
    logic [1:0] rst_sync_ff;
    logic       rst_n;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // three-stage pin filter: a change counts once stages two and three agree
    localparam int PW = $bits(cie_pins_t);
    cie_pins_t raw;
    logic [PW-1:0] s1_ff, s2_ff, s3_ff, flt_ff, nxt_flt;
    cie_pins_t pin;

    assign raw = '{irq: IRQ, switches: PANEL_SWITCHES, serial_in: SERIAL_IN,
                   restart: PANEL_RESTART, power_ok: POWER_OK};
    assign pin = cie_pins_t'(flt_ff);

    generate
        for (genvar g = 0; g < PW; g++) begin : g_filt
            always_comb begin
                nxt_flt[g] = (s2_ff[g] == s3_ff[g]) ? s3_ff[g] : flt_ff[g];
            end
        end
    endgenerate

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            s1_ff  <= '0;
            s2_ff  <= '0;
            s3_ff  <= '0;
            flt_ff <= '0;
        end else begin
            s1_ff  <= raw;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            flt_ff <= nxt_flt;
        end
    end

    // instruction field decode used by both instruction groups
    function automatic logic is_op(input logic [15:0] w, input logic [3:0] op);
        return w[`CIE_OP_HI:`CIE_OP_LO] == op;
    endfunction

    cie_state_t state_ff, nxt_state;
    cie_arch_t  arch_ff, nxt_arch;
    logic       inhibit_ff, nxt_inhibit;
    logic       restart_q_ff, power_q_ff;
    logic       skip_ff, nxt_skip, done_ff, nxt_done, take_ff, nxt_take;
    logic       shut_ff, nxt_shut, start_ff, nxt_start, ready_ff, nxt_ready;

    logic       exec, is_cmd, is_imm, logical, arith, irq_pend, restart_rise, power_rise;
    logic [7:0] lit, res;
    logic [8:0] sum9, dif9;
    logic       cres;

    assign exec         = INSTR_VALID && (state_ff == CIE_RUN);
    assign is_cmd       = is_op(INSTR, `CIE_OP_COMMAND);
    assign logical      = is_op(INSTR, `CIE_OP_AND_IMM) || is_op(INSTR, `CIE_OP_OR_IMM)
                       || is_op(INSTR, `CIE_OP_XOR_IMM);
    assign arith        = is_op(INSTR, `CIE_OP_ADD_IMM) || is_op(INSTR, `CIE_OP_SUB_IMM);
    assign is_imm       = logical || arith || is_op(INSTR, `CIE_OP_LOAD_IMM);
    assign lit          = INSTR[7:0]; // RQ13
    assign irq_pend     = |(pin.irq & arch_ff.mask) && arch_ff.enable;
    assign restart_rise = pin.restart && !restart_q_ff;
    assign power_rise   = pin.power_ok && !power_q_ff;
    assign sum9         = {1'b0, arch_ff.acc} + {1'b0, lit}; // RQ13
    assign dif9         = {1'b0, arch_ff.acc} - {1'b0, lit};

    always_comb begin
        res  = lit;
        cres = arch_ff.carry;
        if (is_op(INSTR, `CIE_OP_AND_IMM)) begin
            res = arch_ff.acc & lit; // RQ17
        end else if (is_op(INSTR, `CIE_OP_OR_IMM)) begin
            res = arch_ff.acc | lit; // RQ17
        end else if (is_op(INSTR, `CIE_OP_XOR_IMM)) begin
            res = arch_ff.acc ^ lit; // RQ17
        end else if (is_op(INSTR, `CIE_OP_ADD_IMM)) begin
            res  = sum9[7:0]; // RQ18
            cres = sum9[8];
        end else if (is_op(INSTR, `CIE_OP_SUB_IMM)) begin
            res  = dif9[7:0]; // RQ19
            cres = dif9[8];
        end
    end

    always_comb begin
        nxt_state   = state_ff;
        nxt_arch    = arch_ff;
        nxt_inhibit = inhibit_ff;
        nxt_skip    = 1'b0;
        nxt_done    = 1'b0;
        nxt_take    = 1'b0;
        nxt_shut    = 1'b0;
        nxt_start   = 1'b0;
        case (state_ff)
            CIE_RUN: begin
                if (exec && is_cmd) begin
                    // the program never pairs load-mask with load-A, so the mask
                    // takes the accumulator as it stood before the instruction
                    if (INSTR[`CIE_FN_SER_OUT]) begin
                        nxt_arch.ser_out = arch_ff.carry; // RQ3
                    end
                    if (INSTR[`CIE_FN_LOAD_A]) begin
                        nxt_arch.acc = pin.switches; // RQ4
                    end
                    if (INSTR[`CIE_FN_LOAD_MASK]) begin
                        nxt_arch.mask = arch_ff.acc; // RQ5 RQ12
                    end
                    if (INSTR[`CIE_FN_SER_IN]) begin
                        nxt_arch.carry = pin.serial_in; // RQ6
                    end
                    if (INSTR[`CIE_FN_SET_EN]) begin
                        nxt_arch.enable = 1'b1; // RQ7
                    end
                    if (INSTR[`CIE_FN_CLR_EN]) begin
                        nxt_arch.enable = 1'b0; // RQ7
                    end
                    // skip looks at the values after every function took effect
                    nxt_skip = (INSTR[`CIE_MOD_NC] && !nxt_arch.carry) // RQ1 RQ20
                            || (INSTR[`CIE_MOD_SKIP_IF_NOT_NEGATIVE] && !nxt_arch.acc[7]);
                    nxt_inhibit = 1'b1; // RQ2
                    nxt_done    = 1'b1;
                    if (INSTR[`CIE_FN_SHUTDOWN]) begin
                        nxt_state = CIE_DOWN; // RQ10
                        nxt_shut  = 1'b1;
                    end else if (INSTR[`CIE_FN_WAIT]) begin
                        nxt_state = CIE_WAIT; // RQ8
                    end
                end else if (exec) begin
                    if (is_imm && !INSTR[`CIE_MOD_N]) begin
                        nxt_arch.acc   = res; // RQ15 RQ16
                        nxt_arch.carry = cres; // RQ15 RQ16 RQ17
                    end
                    if (is_imm) begin
                        nxt_skip = (INSTR[`CIE_MOD_SKIP_IF_NOT_NEGATIVE] && !res[7]) // RQ14
                                || (INSTR[`CIE_MOD_SKIP_IF_RESULT_NOT_ZERO] && logical && |res)
                                || (INSTR[`CIE_MOD_NC] && arith && !cres); // RQ14
                    end
                    nxt_inhibit = 1'b0; // RQ2 RQ9
                    nxt_done    = 1'b1;
                end else if (irq_pend && !inhibit_ff && !take_ff) begin
                    nxt_take = 1'b1; // RQ2
                end
            end
            CIE_WAIT: begin
                // the interrupt releases the wait, but the inhibit left by the
                // command still lets the following instruction run first
                if (irq_pend || restart_rise) begin
                    nxt_state = CIE_RUN; // RQ8 RQ9
                end
            end
            CIE_DOWN: begin
                if (power_rise) begin
                    nxt_state   = CIE_RUN; // RQ11
                    nxt_start   = 1'b1;
                    nxt_inhibit = 1'b0;
                end
            end
            default: begin
                nxt_state = CIE_RUN;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_ff     <= CIE_RUN;
            arch_ff      <= '{acc: `CIE_RST_BYTE, carry: 1'b0, mask: `CIE_RST_BYTE,
                              enable: 1'b0, ser_out: 1'b0};
            inhibit_ff   <= 1'b0;
            restart_q_ff <= 1'b0;
            power_q_ff   <= 1'b0;
            skip_ff      <= 1'b0;
            done_ff      <= 1'b0;
            take_ff      <= 1'b0;
            shut_ff      <= 1'b0;
            start_ff     <= 1'b0;
            ready_ff     <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            arch_ff      <= nxt_arch;
            inhibit_ff   <= nxt_inhibit;
            restart_q_ff <= pin.restart;
            power_q_ff   <= pin.power_ok;
            skip_ff      <= nxt_skip;
            done_ff      <= nxt_done;
            take_ff      <= nxt_take;
            shut_ff      <= nxt_shut;
            start_ff     <= nxt_start;
            ready_ff     <= nxt_ready;
        end
    end

    // ready falls on the same edge that enters wait or shutdown
    assign nxt_ready = (nxt_state == CIE_RUN);

    assign INSTR_READY   = ready_ff;
    assign ACC           = arch_ff.acc;
    assign CARRY         = arch_ff.carry;
    assign INT_MASK      = arch_ff.mask;
    assign INT_ENABLE    = arch_ff.enable;
    assign SERIAL_OUT    = arch_ff.ser_out;
    assign SKIP          = skip_ff;
    assign DONE          = done_ff;
    assign INT_TAKE      = take_ff;
    assign WAITING       = (state_ff == CIE_WAIT);
    assign SHUTDOWN_INIT = shut_ff;
    assign START_ZERO    = start_ff;
    assign START_PC      = `CIE_RESTART_PC;

    property p_no_int_after_cmd;
        @(posedge CLK) disable iff (!rst_n)
        (exec && is_cmd) ##1 !exec |=> !INT_TAKE;
    endproperty
    a_no_int_after_cmd: assert property (p_no_int_after_cmd) // RQ2
        else $error("interrupt taken right after a command");
    property p_ser_out;
        @(posedge CLK) disable iff (!rst_n)
        (exec && is_cmd && INSTR[`CIE_FN_SER_OUT]) |=>
            (SERIAL_OUT == $past(CARRY) && CARRY == $past(CARRY) || $past(INSTR[`CIE_FN_SER_IN]));
    endproperty
    a_ser_out: assert property (p_ser_out) // RQ3
        else $error("serial output does not carry the carry flag");
    property p_load_a;
        @(posedge CLK) disable iff (!rst_n)
        (exec && is_cmd && INSTR[`CIE_FN_LOAD_A]) |=> ACC == $past(pin.switches);
    endproperty
    a_load_a: assert property (p_load_a) // RQ4
        else $error("accumulator not loaded from switches");
    property p_load_mask;
        @(posedge CLK) disable iff (!rst_n)
        (exec && is_cmd && INSTR[`CIE_FN_LOAD_MASK] && !INSTR[`CIE_FN_LOAD_A])
            |=> INT_MASK == $past(ACC) && $stable(ACC);
    endproperty
    a_load_mask: assert property (p_load_mask) // RQ5
        else $error("mask not loaded from accumulator");
    property p_enable;
        @(posedge CLK) disable iff (!rst_n)
        (exec && is_cmd && (INSTR[`CIE_FN_SET_EN] != INSTR[`CIE_FN_CLR_EN]))
            |=> INT_ENABLE == $past(INSTR[`CIE_FN_SET_EN]);
    endproperty
    a_enable: assert property (p_enable) // RQ7
        else $error("enable flag wrong after command");
    property p_wait;
        @(posedge CLK) disable iff (!rst_n)
        (exec && is_cmd && INSTR[`CIE_FN_WAIT] && !INSTR[`CIE_FN_SHUTDOWN])
            |=> WAITING && !INSTR_READY;
    endproperty
    a_wait: assert property (p_wait) // RQ8
        else $error("wait command did not halt");
    property p_wake_then_instr;
        @(posedge CLK) disable iff (!rst_n)
        (WAITING && irq_pend) |=> !WAITING && !INT_TAKE;
    endproperty
    a_wake_then_instr: assert property (p_wake_then_instr) // RQ9
        else $error("interrupt taken before instruction after wait");
    property p_suppress;
        @(posedge CLK) disable iff (!rst_n)
        (exec && is_imm && INSTR[`CIE_MOD_N]) |=> $stable(ACC) && $stable(CARRY);
    endproperty
    a_suppress: assert property (p_suppress) // RQ15
        else $error("suppressed result changed accumulator or carry");
    property p_add;
        @(posedge CLK) disable iff (!rst_n)
        (exec && is_op(INSTR, `CIE_OP_ADD_IMM) && !INSTR[`CIE_MOD_N])
            |=> {CARRY, ACC} == ({1'b0, $past(ACC)} + {1'b0, $past(INSTR[7:0])});
    endproperty
    a_add: assert property (p_add) // RQ18
        else $error("add immediate result wrong");
    property p_restart;
        @(posedge CLK) disable iff (!rst_n)
        (state_ff == CIE_DOWN && power_rise) |=> START_ZERO && START_PC == 16'h0000;
    endproperty
    a_restart: assert property (p_restart) // RQ11
        else $error("no restart at zero after power return");
endmodule

/* File: cie_panel.sv */
// control panel, serial bit port and interrupt source beside the executor
// assumes the bench sets the wanted pin levels in req; they reach the pins at a falling edge
`timescale 1ns/1ps
module cie_panel
    import cie_pkg::*;
(
    input  wire logic      clk,
    input  wire cie_pins_t req,
    output cie_pins_t      pins
);
    // switches and lines are held levels; pushbutton bounce is not modelled
    initial pins = '{irq: 8'h00, switches: 8'h00, serial_in: 1'b0, restart: 1'b0,
                     power_ok: 1'b1};
    always @(negedge clk) begin
        pins <= req;
    end
endmodule

/* File: command_immediate_exec_test.sv */
// self-checking bench for the command and immediate executor
// assumes cie_panel drives the pins and the bench plays the instruction sequencer
`timescale 1ns/1ps
module command_immediate_exec_test;
    import cie_pkg::*;
    logic        clk;
    logic        arst_n;
    logic        ivalid;
    logic [15:0] instr;
    cie_pins_t   req;
    cie_pins_t   pins;
    logic        ready, carry, ie, sout, skip, done, take, waiting, shut, szero;
    logic [7:0]  acc, mask;
    logic [15:0] spc;
    logic [7:0]  ea;
    logic        ec;
    logic        s_skip, s_done, s_shut, s_waiting;
    int          failures;
    int          total_checks;
    int          cycles;

    cie_panel panel (.clk(clk), .req(req), .pins(pins));
    cie_exec dut (
        .CLK(clk), .ARST_N(arst_n), .INSTR_VALID(ivalid), .INSTR(instr),
        .PANEL_SWITCHES(pins.switches), .SERIAL_IN(pins.serial_in),
        .PANEL_RESTART(pins.restart), .POWER_OK(pins.power_ok), .IRQ(pins.irq),
        .INSTR_READY(ready), .ACC(acc), .CARRY(carry), .INT_MASK(mask),
        .INT_ENABLE(ie), .SERIAL_OUT(sout), .SKIP(skip), .DONE(done),
        .INT_TAKE(take), .WAITING(waiting), .SHUTDOWN_INIT(shut),
        .START_ZERO(szero), .START_PC(spc)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task print_verdict();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // a clean run costs far less than this; normal runs take under two hundred cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures = failures + 1;
            print_verdict();
        end
    end

    task chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    // polls a flag at falling edges; 0 start-from-zero, 1 interrupt take, 2 ready
    task expect_sig(input int which, input int lim);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < lim && !seen; i++) begin
            @(negedge clk);
            case (which)
                0: seen = (szero === 1'b1);
                1: seen = (take === 1'b1);
                default: seen = (ready === 1'b1);
            endcase
        end
        chk({15'h0000, seen}, 16'h0001);
    endtask

    task no_take(input int n);
        repeat (n) begin
            @(negedge clk);
            chk({15'h0000, take}, 16'h0000);
        end
    endtask

    task exec(input logic [15:0] w);
        int i;
        i = 0;
        // one idle edge, so ivalid never falls and rises in the same time step
        @(negedge clk);
        while (ready !== 1'b1 && i < 20) begin
            @(negedge clk);
            i++;
        end
        instr  = w;
        ivalid = 1'b1;
        @(negedge clk);
        ivalid = 1'b0;
        s_done = done;
        s_skip = skip;
        s_shut = shut;
        s_waiting = waiting;
    endtask

    // the bench never issues conflicting function pairs in one command
    task cmd(input logic [3:0] md, input logic [7:0] fn);
        exec({4'h1, md, fn});
        chk({15'h0000, s_done}, 16'h0001);
    endtask

    task imm(input logic [3:0] op, input logic [3:0] md, input logic [7:0] lit);
        logic [8:0] r;
        logic       c;
        logic       ar;
        logic       sk;
        logic       lg;
        c = ec;
        ar = (op > 4'h5);
        // load is neither logical nor arithmetic: not-zero skip only on and, or, xor
        lg = (op > 4'h2) && !ar;
        case (op)
            4'h2: r = {1'b0, lit};
            4'h3: r = {1'b0, ea & lit};
            4'h4: r = {1'b0, ea | lit};
            4'h5: r = {1'b0, ea ^ lit};
            4'h6: r = {1'b0, ea} + {1'b0, lit};
            default: r = {1'b0, ea} - {1'b0, lit};
        endcase
        if (ar) begin
            c = r[8];
        end
        sk = (md[2] && !r[7]) || (md[1] && lg && r[7:0] != 8'h00) || (md[0] && ar && !c);
        exec({op, md, lit});
        if (!md[3]) begin
            ea = r[7:0];
            ec = c;
        end
        chk({8'h00, acc}, {8'h00, ea});
        chk({15'h0000, carry}, {15'h0000, ec});
        chk({15'h0000, s_skip}, {15'h0000, sk});
    endtask

    task s_imm();
        imm(4'h2, 4'b0000, 8'h3C);
        imm(4'h3, 4'b0100, 8'h0F);
        imm(4'h4, 4'b0010, 8'hC0);
        imm(4'h5, 4'b1010, 8'hCC);
        imm(4'h6, 4'b0001, 8'h40);
        imm(4'h7, 4'b0001, 8'h20);
        imm(4'h6, 4'b1001, 8'h01);
        imm(4'h4, 4'b0001, 8'h00);
        imm(4'h7, 4'b0010, 8'h00);
        imm(4'h2, 4'b1010, 8'h81);
    endtask

    task s_panel();
        req.switches = 8'h5A;
        idle(6);
        cmd(4'b0100, 8'h40);
        ea = 8'h5A;
        chk({8'h00, acc}, 16'h005A);
        chk({15'h0000, s_skip}, 16'h0001);
        cmd(4'b0000, 8'h20);
        chk({8'h00, mask}, 16'h005A);
        chk({8'h00, acc}, 16'h005A);
    endtask

    task s_serial();
        imm(4'h6, 4'b0000, 8'hFF);
        cmd(4'b0000, 8'h80);
        chk({14'h0000, sout, carry}, 16'h0003);
        req.serial_in = 1'b0;
        idle(6);
        cmd(4'b0001, 8'h10);
        ec = 1'b0;
        chk({15'h0000, carry}, 16'h0000);
        chk({15'h0000, s_skip}, 16'h0001);
    endtask

    task s_int();
        req.irq = 8'h02;
        idle(6);
        cmd(4'b0000, 8'h08);
        chk({15'h0000, ie}, 16'h0001);
        no_take(6);
        imm(4'h4, 4'b0000, 8'h00);
        expect_sig(1, 6);
        req.irq = 8'h00;
        idle(6);
        cmd(4'b0000, 8'h04);
        chk({15'h0000, ie}, 16'h0000);
    endtask

    task s_wait();
        cmd(4'b0000, 8'h02);
        chk({15'h0000, s_waiting}, 16'h0001);
        idle(5);
        chk({14'h0000, waiting, ready}, 16'h0002);
        req.restart = 1'b1;
        expect_sig(2, 12);
        chk({15'h0000, waiting}, 16'h0000);
        req.restart = 1'b0;
        idle(6);
        cmd(4'b0000, 8'h0A);
        idle(4);
        req.irq = 8'h02;
        expect_sig(2, 12);
        no_take(4);
        imm(4'h4, 4'b0000, 8'h00);
        expect_sig(1, 6);
        req.irq = 8'h00;
        idle(6);
        cmd(4'b0000, 8'h04);
    endtask

    task s_power();
        req.power_ok = 1'b0;
        idle(6);
        cmd(4'b0000, 8'h01);
        chk({15'h0000, s_shut}, 16'h0001);
        idle(6);
        chk({15'h0000, ready}, 16'h0000);
        req.power_ok = 1'b1;
        expect_sig(0, 12);
        chk(spc, 16'h0000);
        expect_sig(2, 4);
    endtask

    initial begin
        arst_n = 1'b0;
        ivalid = 1'b0;
        instr = 16'h0000;
        req = '{irq: 8'h00, switches: 8'h00, serial_in: 1'b0, restart: 1'b0, power_ok: 1'b1};
        ea = 8'h00;
        ec = 1'b0;
        failures = 0;
        total_checks = 0;
        cycles = 0;
        repeat (12) @(negedge clk);
        arst_n = 1'b1;
        expect_sig(2, 10);
        idle(6);
        chk({acc, 7'h00, carry}, 16'h0000);
        s_imm();
        s_panel();
        s_serial();
        s_int();
        s_wait();
        s_power();
        print_verdict();
    end
endmodule
